/* File: tocu_top.sv */
// 8-bit timer output compare unit with axi4-lite register access
// assumes axi4-lite master in the core clock domain, port pin logic outside
`timescale 1ns/100ps
module tocu_top
	import tocu_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [TOCU_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [TOCU_DATA_W-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [TOCU_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [TOCU_DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic port_data_in,
	input wire logic pin_direction_bit_in,
	input wire logic match_irq_ack_in,
	output logic pin_value_out,
	output logic pin_oe_n_out,
	output logic compare_match_flag_out
);
	////////////////////////////////////////////////////////////////////////
	// bus slave state
	logic aw_hold_ff, nxt_aw_hold;
	logic w_hold_ff, nxt_w_hold;
	logic [TOCU_ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic [TOCU_DATA_W-1:0] wdata_ff, nxt_wdata;
	logic wstrb0_ff, nxt_wstrb0;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [TOCU_DATA_W-1:0] rdata_ff, nxt_rdata;
	logic wr_go, wr_ctrl, wr_count, wr_cmp, wr_stat;

	// timer state
	logic [2:0] cs_ff, nxt_cs;
	logic [1:0] wgm_ff, nxt_wgm;
	logic [1:0] com_ff, nxt_com;
	logic [7:0] count_ff, nxt_count;
	logic down_ff, nxt_down;
	logic [7:0] cmp_act_ff, nxt_cmp_act;
	logic [7:0] cmp_buf_ff, nxt_cmp_buf;
	logic out_ff, nxt_out;
	logic match_flag_ff, nxt_match_flag;
	logic tov_ff, nxt_tov;
	logic block_ff, nxt_block;
	logic tick, is_pwm, match, match_ok, force_hit;
	logic [7:0] cmp_view;

	tocu_tick u_tick (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_sel_in(cs_ff),
		.tick_out(tick)
	);

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write and read channels
	assign s_axi_awready_out = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready_out = !w_hold_ff && !bvalid_ff;
	assign s_axi_bvalid_out = bvalid_ff;
	assign s_axi_bresp_out = bresp_ff;
	assign s_axi_arready_out = !rvalid_ff;
	assign s_axi_rvalid_out = rvalid_ff;
	assign s_axi_rresp_out = rresp_ff;
	assign s_axi_rdata_out = rdata_ff;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold = w_hold_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb0 = wstrb0_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			nxt_w_hold = 1'b1;
			nxt_wdata = s_axi_wdata_in;
			nxt_wstrb0 = s_axi_wstrb_in[0];
		end
		wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
		if (wr_go) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold = 1'b0;
			nxt_bvalid = 1'b1;
			case (awaddr_ff)
				TOCU_OFS_CTRL, TOCU_OFS_COUNT, TOCU_OFS_CMP, TOCU_OFS_STAT:
					nxt_bresp = TOCU_RESP_OKAY;
				default: nxt_bresp = TOCU_RESP_SLVERR;
			endcase
		end
		if (bvalid_ff && s_axi_bready_in) begin
			nxt_bvalid = 1'b0;
		end
		wr_ctrl = wr_go && wstrb0_ff && (awaddr_ff == TOCU_OFS_CTRL);
		wr_count = wr_go && wstrb0_ff && (awaddr_ff == TOCU_OFS_COUNT);
		wr_cmp = wr_go && wstrb0_ff && (awaddr_ff == TOCU_OFS_CMP);
		wr_stat = wr_go && wstrb0_ff && (awaddr_ff == TOCU_OFS_STAT);
	end

	// compare reads return the register the cpu currently addresses
	assign cmp_view = is_pwm ? cmp_buf_ff : cmp_act_ff;

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = TOCU_RESP_OKAY;
			nxt_rdata = '0;
			case (s_axi_araddr_in)
				TOCU_OFS_CTRL: begin
					nxt_rdata[TOCU_CTRL_CS_LSB +: 3] = cs_ff;
					nxt_rdata[TOCU_CTRL_WGM_LSB +: 2] = wgm_ff;
					nxt_rdata[TOCU_CTRL_COM_LSB +: 2] = com_ff;
				end
				TOCU_OFS_COUNT: nxt_rdata[7:0] = count_ff;
				TOCU_OFS_CMP: nxt_rdata[7:0] = cmp_view;
				TOCU_OFS_STAT: begin
					nxt_rdata[TOCU_STAT_MATCH_BIT] = match_flag_ff;
					nxt_rdata[TOCU_STAT_TOV_BIT] = tov_ff;
					nxt_rdata[TOCU_STAT_OUT_BIT] = out_ff;
					nxt_rdata[TOCU_STAT_DIR_BIT] = down_ff;
				end
				default: nxt_rresp = TOCU_RESP_SLVERR;
			endcase
		end else if (rvalid_ff && s_axi_rready_in) begin
			nxt_rvalid = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter, compare and waveform logic
	assign is_pwm = (wgm_ff == TOCU_WGM_PCPWM) || (wgm_ff == TOCU_WGM_FAST);
	assign match = (count_ff == cmp_act_ff);
	assign match_ok = tick && match && !block_ff;
	// force bit is a strobe: acted on during a write in normal or ctc mode, never stored
	assign force_hit = wr_ctrl && !is_pwm && wr_ctrl_force(wdata_ff);

	function automatic logic wr_ctrl_force(input logic [TOCU_DATA_W-1:0] d);
		return d[TOCU_CTRL_FOC_BIT];
	endfunction

	always_comb begin
		nxt_cs = cs_ff;
		nxt_wgm = wgm_ff;
		nxt_com = com_ff;
		nxt_count = count_ff;
		nxt_down = down_ff;
		nxt_cmp_act = cmp_act_ff;
		nxt_cmp_buf = cmp_buf_ff;
		nxt_out = out_ff;
		nxt_match_flag = match_flag_ff;
		// a clear written now loses to an overflow event below
		nxt_tov = tov_ff && !(wr_stat && wdata_ff[TOCU_STAT_TOV_BIT]);
		nxt_block = block_ff;
		if (tick) begin
			nxt_block = 1'b0;
			// counting ignores the action field
			case (wgm_ff)
				TOCU_WGM_NORMAL: begin
					nxt_count = count_ff + 8'h01;
					if (count_ff == TOCU_MAX) nxt_tov = 1'b1;
				end
				TOCU_WGM_CTC: begin
					if (match) begin
						nxt_count = TOCU_BOTTOM;
					end else begin
						nxt_count = count_ff + 8'h01;
					end
					if (count_ff == TOCU_MAX) nxt_tov = 1'b1;
				end
				TOCU_WGM_FAST: begin
					nxt_count = count_ff + 8'h01;
					if (count_ff == TOCU_MAX) begin
						nxt_tov = 1'b1;
						nxt_cmp_act = cmp_buf_ff;
					end
				end
				TOCU_WGM_PCPWM: begin
					if (!down_ff && count_ff == TOCU_MAX) begin
						nxt_down = 1'b1;
						nxt_count = count_ff - 8'h01;
						nxt_cmp_act = cmp_buf_ff;
					end else if (down_ff && count_ff == TOCU_BOTTOM) begin
						nxt_down = 1'b0;
						nxt_count = count_ff + 8'h01;
						nxt_tov = 1'b1;
					end else begin
						nxt_count = down_ff ? count_ff - 8'h01 : count_ff + 8'h01;
					end
				end
				default: nxt_count = count_ff;
			endcase
			if (match_ok) nxt_match_flag = 1'b1;
			// waveform action uses the live action field
			if (match_ok) begin
				case (com_ff)
					TOCU_COM_TOGGLE: nxt_out = !out_ff;
					TOCU_COM_CLEAR: begin
						if (wgm_ff == TOCU_WGM_PCPWM) nxt_out = down_ff;
						else nxt_out = 1'b0;
					end
					TOCU_COM_SET: begin
						if (wgm_ff == TOCU_WGM_PCPWM) nxt_out = !down_ff;
						else nxt_out = 1'b1;
					end
					default: nxt_out = out_ff;
				endcase
			end else if (wgm_ff == TOCU_WGM_FAST && count_ff == TOCU_MAX) begin
				if (com_ff == TOCU_COM_CLEAR) nxt_out = 1'b1;
				if (com_ff == TOCU_COM_SET) nxt_out = 1'b0;
			end
		end
		// force touches only the output state
		if (force_hit) begin
			case (com_ff)
				TOCU_COM_TOGGLE: nxt_out = !out_ff;
				TOCU_COM_CLEAR: nxt_out = 1'b0;
				TOCU_COM_SET: nxt_out = 1'b1;
				default: nxt_out = out_ff;
			endcase
		end
		// set wins over a simultaneous clear
		if ((wr_stat && wdata_ff[TOCU_STAT_MATCH_BIT]) || match_irq_ack_in) begin
			if (!match_ok) nxt_match_flag = 1'b0;
		end
		if (wr_ctrl) begin
			nxt_cs = wdata_ff[TOCU_CTRL_CS_LSB +: 3];
			nxt_wgm = wdata_ff[TOCU_CTRL_WGM_LSB +: 2];
			nxt_com = wdata_ff[TOCU_CTRL_COM_LSB +: 2];
		end
		if (wr_cmp) begin
			if (is_pwm) nxt_cmp_buf = wdata_ff[7:0];
			else nxt_cmp_act = wdata_ff[7:0];
			if (!is_pwm) nxt_cmp_buf = wdata_ff[7:0];
		end
		// cpu write wins over count; blocks match flag and output action, not the ctc clear, until next tick ends
		if (wr_count) begin
			nxt_count = wdata_ff[7:0];
			nxt_block = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin override
	always_comb begin
		pin_value_out = (com_ff != TOCU_COM_NONE) ? out_ff : port_data_in;
		pin_oe_n_out = !pin_direction_bit_in;
	end
	assign compare_match_flag_out = match_flag_ff;

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= TOCU_RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= TOCU_RESP_OKAY;
			rdata_ff <= '0;
			cs_ff <= 3'h0;
			wgm_ff <= TOCU_WGM_NORMAL;
			com_ff <= TOCU_COM_NONE;
			count_ff <= TOCU_RST_COUNT;
			down_ff <= 1'b0;
			cmp_act_ff <= TOCU_RST_CMP;
			cmp_buf_ff <= TOCU_RST_CMP;
			out_ff <= 1'b0;
			match_flag_ff <= 1'b0;
			tov_ff <= 1'b0;
			block_ff <= 1'b0;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb0_ff <= nxt_wstrb0;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			cs_ff <= nxt_cs;
			wgm_ff <= nxt_wgm;
			com_ff <= nxt_com;
			count_ff <= nxt_count;
			down_ff <= nxt_down;
			cmp_act_ff <= nxt_cmp_act;
			cmp_buf_ff <= nxt_cmp_buf;
			out_ff <= nxt_out;
			match_flag_ff <= nxt_match_flag;
			tov_ff <= nxt_tov;
			block_ff <= nxt_block;
		end
	end
endmodule // tocu_top

/* File: tocu_pkg.sv */
// package for the 8-bit timer output compare unit
// assumes a single 40 MHz clock domain and an AXI4-Lite register bus
package tocu_pkg;
	localparam int TOCU_DATA_W = 32;
	localparam int TOCU_ADDR_W = 8;
	localparam logic [7:0] TOCU_OFS_CTRL = 8'h00;
	localparam logic [7:0] TOCU_OFS_COUNT = 8'h04;
	localparam logic [7:0] TOCU_OFS_CMP = 8'h08;
	localparam logic [7:0] TOCU_OFS_STAT = 8'h0c;
	localparam int TOCU_CTRL_CS_LSB = 0;
	localparam int TOCU_CTRL_WGM_LSB = 3;
	localparam int TOCU_CTRL_COM_LSB = 5;
	localparam int TOCU_CTRL_FOC_BIT = 7;
	localparam int TOCU_STAT_MATCH_BIT = 0;
	localparam int TOCU_STAT_TOV_BIT = 1;
	localparam int TOCU_STAT_OUT_BIT = 2;
	localparam int TOCU_STAT_DIR_BIT = 3;
	localparam logic [1:0] TOCU_WGM_NORMAL = 2'h0;
	localparam logic [1:0] TOCU_WGM_PCPWM = 2'h1;
	localparam logic [1:0] TOCU_WGM_CTC = 2'h2;
	localparam logic [1:0] TOCU_WGM_FAST = 2'h3;
	localparam logic [1:0] TOCU_COM_NONE = 2'h0;
	localparam logic [1:0] TOCU_COM_TOGGLE = 2'h1;
	localparam logic [1:0] TOCU_COM_CLEAR = 2'h2;
	localparam logic [1:0] TOCU_COM_SET = 2'h3;
	localparam logic [7:0] TOCU_BOTTOM = 8'h00;
	localparam logic [7:0] TOCU_MAX = 8'hff;
	localparam logic [7:0] TOCU_RST_CMP = 8'h00;
	localparam logic [7:0] TOCU_RST_COUNT = 8'h00;
	localparam logic [9:0] TOCU_PRE_8 = 10'h007;
	localparam logic [9:0] TOCU_PRE_64 = 10'h03f;
	localparam logic [9:0] TOCU_PRE_256 = 10'h0ff;
	localparam logic [9:0] TOCU_PRE_1024 = 10'h3ff;
	localparam logic [1:0] TOCU_RESP_OKAY = 2'h0;
	localparam logic [1:0] TOCU_RESP_SLVERR = 2'h2;
endpackage

/* File: tocu_tick.sv */
// timer clock enable generator: prescaled tick from the i/o clock
// assumes clock select 0 stops the timer clock entirely
`timescale 1ns/100ps
module tocu_tick
	import tocu_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [2:0] clk_sel_in,
	output logic tick_out
);
	logic [9:0] pre_ff;
	logic [9:0] nxt_pre;
	logic hit;

	always_comb begin
		nxt_pre = pre_ff + 10'h001;
		case (clk_sel_in)
			3'h1: hit = 1'b1;
			3'h2: hit = (pre_ff[2:0] == TOCU_PRE_8[2:0]);
			3'h3: hit = (pre_ff[5:0] == TOCU_PRE_64[5:0]);
			3'h4: hit = (pre_ff[7:0] == TOCU_PRE_256[7:0]);
			3'h5: hit = (pre_ff == TOCU_PRE_1024);
			default: hit = 1'b0;
		endcase
		if (clk_sel_in == 3'h0) begin
			nxt_pre = 10'h000;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pre_ff <= 10'h000;
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	assign tick_out = hit;
endmodule // tocu_tick

/* File: tocu_top_sva.sv */
// port checker for the 8-bit timer output compare unit
// assumes one clock domain and binding onto tocu_top
`timescale 1ns/100ps
module tocu_top_chk
	import tocu_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic port_data_in,
	input wire logic pin_direction_bit_in,
	input wire logic match_irq_ack_in,
	input wire logic pin_value_out,
	input wire logic pin_oe_n_out,
	input wire logic compare_match_flag_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (sys_rst_in);
////////////////////////////////////////////////////////////////////////
sequence s_wr_taken;
	s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
		s_axi_wready_out;
endsequence
sequence s_wr_answer;
	!s_axi_bvalid_out ##1 s_axi_bvalid_out;
endsequence
AST_WR_RESP: assert property (s_wr_taken |=> s_wr_answer)
	else $error("write response late or early");
AST_WR_BUSY: assert property (s_axi_bvalid_out |->
	!s_axi_awready_out && !s_axi_wready_out)
	else $error("write channel ready during response");
AST_B_DROP: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
	!s_axi_bvalid_out)
	else $error("write response not released");
AST_AR_RESP: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
	s_axi_rvalid_out)
	else $error("read data not one cycle after address");
AST_AR_READY: assert property (s_axi_arready_out == !s_axi_rvalid_out)
	else $error("read address ready wrong");
AST_R_DROP: assert property (s_axi_rvalid_out && s_axi_rready_in |=>
	!s_axi_rvalid_out)
	else $error("read data not released");
AST_OE_DIR: assert property (pin_oe_n_out == !pin_direction_bit_in)
	else $error("pin enable not following direction");
AST_RST_CLR: assert property ($past(sys_rst_in) |->
	!compare_match_flag_out && pin_value_out == port_data_in)
	else $error("state not cleared by reset");
AST_FLAG_FALL: assert property ($fell(compare_match_flag_out) |->
	$past(match_irq_ack_in) || $rose(s_axi_bvalid_out))
	else $error("match flag cleared without cause");
endmodule // tocu_top_chk
bind tocu_top tocu_top_chk tocu_top_chk_inst (.core_clk_in, .sys_rst_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
	.s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .port_data_in, .pin_direction_bit_in,
	.match_irq_ack_in, .pin_value_out, .pin_oe_n_out,
	.compare_match_flag_out);

/* File: tocu_port_model.sv */
// port pin partner: resolves the pin level seen outside
// assumes a pull-up on the pin while the block does not drive it
`timescale 1ns/100ps
module tocu_port_model (
	input wire logic pin_value_in,
	input wire logic pin_oe_n_in,
	output logic pin_wire_out
);
	// released pin floats up to the pull-up level
	assign pin_wire_out = pin_oe_n_in ? 1'b1 : pin_value_in;
endmodule // tocu_port_model

/* File: timer8_output_compare_unit_tb_top.sv */
// self-checking bench for the output compare unit
// assumes tocu_top, tocu_port_model and the bound checker
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module timer8_output_compare_unit_tb_top
	import tocu_pkg::*;
;
logic clk, rst, awvalid, wvalid, bready, arvalid, rready, pdata, pdir, ack;
logic awready, wready, bvalid, arready, rvalid, pin, oe_n, flag, wire_lvl;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, rdata, d;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rsp;
logic [1:0] acts [5] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2};
int num_errors = 0, tests_run = 0, cyc = 0, st;
integer seed = 32'he22e;
tocu_top tocu_top_inst (
	.core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
	.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
	.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
	.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
	.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
	.s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
	.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
	.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
	.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
	.port_data_in(pdata), .pin_direction_bit_in(pdir),
	.match_irq_ack_in(ack), .pin_value_out(pin), .pin_oe_n_out(oe_n),
	.compare_match_flag_out(flag));
tocu_port_model tocu_port_model_inst (.pin_value_in(pin),
	.pin_oe_n_in(oe_n), .pin_wire_out(wire_lvl));
////////////////////////////////////////////////////////////////////////
initial begin
	clk = 1'b0;
	forever #12.5 clk = ~clk;
end
always @(posedge clk) begin
	cyc++;
	if (cyc == 3000) begin
		num_errors++;
		end_of_test();
	end
end
task end_of_test;
	begin
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	end
endtask
task wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
	logic aw, w, b;
	begin
		@(posedge clk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
	end
endtask
task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
	logic ar, v;
	begin
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge clk);
			ar = arvalid && arready;
			v = rvalid;
			dv = rdata;
			r = rresp;
			@(posedge clk);
			if (ar) arvalid <= 1'b0;
			if (v) rready <= 1'b0;
		end
	end
endtask
task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
	begin
		rd(a, d, rsp);
		`CHK(d, e)
		`CHK(rsp, r)
	end
endtask
// output state and match flag from the status word
task sflag(input int s, input int f);
	begin
		rd(TOCU_OFS_STAT, d, rsp);
		`CHK(d[TOCU_STAT_OUT_BIT], 1'(s))
		`CHK(d[TOCU_STAT_MATCH_BIT], 1'(f))
		`CHK(flag, 1'(f))
	end
endtask
task pchk(input logic e);
	begin
		@(negedge clk);
		`CHK(pin, e)
	end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	rst = 1'b1;
	{awvalid, wvalid, bready, arvalid, rready, pdata, pdir, ack} = 8'h00;
	awaddr = 8'h00;
	araddr = 8'h00;
	wdata = 32'h0;
	wstrb = 4'hf;
	repeat (20) @(posedge clk);
	rst <= 1'b0;
	for (int i = 0; i < 4; i++) rchk(8'(i * 4), 32'h0, TOCU_RESP_OKAY);
	rchk(8'h10, 32'h0, TOCU_RESP_SLVERR);
	wr(8'h14, 32'h1, rsp);
	`CHK(rsp, TOCU_RESP_SLVERR)
	repeat (8) begin
		@(posedge clk);
		pdata <= 1'($random(seed));
		pdir <= 1'($random(seed));
		@(negedge clk);
		`CHK(pin, pdata)
		`CHK(wire_lvl, pdir ? pdata : 1'b1)
	end
	st = 0;
	foreach (acts[i]) begin
		wr(TOCU_OFS_CTRL, 32'(acts[i]) << TOCU_CTRL_COM_LSB, rsp);
		wr(TOCU_OFS_CTRL, (32'(acts[i]) << TOCU_CTRL_COM_LSB) | 32'h80, rsp);
		case (acts[i])
			TOCU_COM_SET: st = 1;
			TOCU_COM_CLEAR: st = 0;
			TOCU_COM_TOGGLE: st = st ^ 1;
			default: st = st;
		endcase
		sflag(st, 0);
		pchk(acts[i] != 2'h0 ? 1'(st) : pdata);
	end
	rchk(TOCU_OFS_COUNT, 32'h0, TOCU_RESP_OKAY);
	wr(TOCU_OFS_CTRL, 32'h78, rsp);
	wr(TOCU_OFS_CTRL, 32'hf8, rsp);
	sflag(st, 0);
	rchk(TOCU_OFS_CTRL, 32'h78, TOCU_RESP_OKAY);
	pchk(1'(st));
	wr(TOCU_OFS_CMP, 32'h5a, rsp);
	rchk(TOCU_OFS_CMP, 32'h5a, TOCU_RESP_OKAY);
	wr(TOCU_OFS_CTRL, 32'h0, rsp);
	rchk(TOCU_OFS_CMP, 32'h0, TOCU_RESP_OKAY);
	// counter loaded equal to compare on purpose to show the blocking
	wr(TOCU_OFS_CMP, 32'h10, rsp);
	wr(TOCU_OFS_COUNT, 32'h10, rsp);
	wr(TOCU_OFS_CTRL, 32'h21, rsp);
	sflag(st, 0);
	repeat (300) @(posedge clk);
	st = st ^ 1;
	sflag(st, 1);
	pchk(1'(st));
	wr(TOCU_OFS_STAT, 32'h1, rsp);
	sflag(st, 0);
	repeat (256) @(posedge clk);
	st = st ^ 1;
	sflag(st, 1);
	@(posedge clk);
	ack <= 1'b1;
	@(posedge clk);
	ack <= 1'b0;
	sflag(st, 0);
	// fast pwm, non-inverted: a buffered compare waits for the wrap
	wr(TOCU_OFS_CTRL, 32'h60, rsp);
	wr(TOCU_OFS_CTRL, 32'he0, rsp);
	st = 1;
	wr(TOCU_OFS_CTRL, 32'h58, rsp);
	wr(TOCU_OFS_CMP, 32'h80, rsp);
	rchk(TOCU_OFS_CMP, 32'h80, TOCU_RESP_OKAY);
	wr(TOCU_OFS_COUNT, 32'h0, rsp);
	sflag(st, 0);
	wr(TOCU_OFS_CTRL, 32'h59, rsp);
	repeat (60) @(posedge clk);
	st = 0;
	sflag(st, 1);
	repeat (250) @(posedge clk);
	st = 1;
	sflag(st, 1);
	repeat (100) @(posedge clk);
	st = 0;
	sflag(st, 1);
	pchk(1'(st));
	end_of_test();
end
endmodule // timer8_output_compare_unit_tb_top
